// ### uart_defs.vh
// register map, field positions and counts of the uart core
`ifndef UART_DEFS_VH
`define UART_DEFS_VH

`define ADDR_STATUS 3'h0
`define ADDR_CTRL1 3'h1
`define ADDR_CTRL2 3'h2
`define ADDR_DATA 3'h3
`define ADDR_BAUD_HI 3'h4
`define ADDR_BAUD_LO 3'h5
`define ADDR_FRAC 3'h6
`define ADDR_COUNT 3'h7

`define CR1_CHANNEL 0
`define CR1_NINE 1
`define CR1_PAREN 2
`define CR1_PTYPE_LO 3
`define CR1_STOP2 5
`define CR1_BREAK 6
`define CR1_TX9 7

`define CR2_TXEN 0
`define CR2_RXEN 1
`define CR2_TEIE 2
`define CR2_RIE 3
`define CR2_TRIG_LO 4

`define CTRL1_RESET 8'h00
`define CTRL2_RESET 8'h00
`define BAUD_RESET 16'h0010
`define FRAC_RESET 3'h0

`define PAR_EVEN 2'h0
`define PAR_ODD 2'h1
`define PAR_MARK 2'h2
`define PAR_SPACE 2'h3

`define BREAK_HOLD_EXTRA 16'h0001
`define BREAK_ZERO_BITS 4'hd
`define FIFO_DEPTH 3'h4
`define VOTE_FIRST 4'h7
`define VOTE_LAST 4'h9
`define PHASE_LAST 4'hf

`endif

// ### uart_tx_rx_core.v
// uart transmitter, receiver, receive fifo and register port
`timescale 1ns/1ps
`include "uart_defs.vh"

module uart_tx_rx_core (
    // clock, reset, enable
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    // register port
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // serial line
    input wire rx_pin,
    output reg tx_out,
    output reg tx_oe,
    // interrupt request
    output reg irq
);

// ==========================================================
// registers and decode
reg [7:0] ctrl1;
reg [7:0] ctrl2;
reg [15:0] baud_divisor;
reg [2:0] baud_fraction_bits;
reg status_seen;
reg tx_empty_flag;
reg tx_idle_flag;
reg rx_idle_flag;
reg overrun_flag;
reg framing_error_flag;
reg parity_error_flag;
reg noise_flag;
reg [2:0] rx_byte_count;
reg [8:0] fifo_mem [0:3];
reg [1:0] fifo_wp;
reg [1:0] fifo_rp;

wire channel_enable_bit = ctrl1[`CR1_CHANNEL];
wire nine_bit_select = ctrl1[`CR1_NINE];
wire parity_enable_bit = ctrl1[`CR1_PAREN];
wire [1:0] parity_type_select = ctrl1[`CR1_PTYPE_LO+1:`CR1_PTYPE_LO];
wire stop_bits_select = ctrl1[`CR1_STOP2];
wire send_break_request = ctrl1[`CR1_BREAK];
wire tx_ninth_bit = ctrl1[`CR1_TX9];
wire tx_enable_bit = ctrl2[`CR2_TXEN] & channel_enable_bit;
wire rx_enable_bit = ctrl2[`CR2_RXEN] & channel_enable_bit;
wire tx_empty_irq_enable = ctrl2[`CR2_TEIE];
wire rx_irq_enable = ctrl2[`CR2_RIE];
wire [2:0] trig_level = {1'b0, ctrl2[`CR2_TRIG_LO+1:`CR2_TRIG_LO]} + 3'h1;
wire rx_ninth_bit = fifo_mem[fifo_rp][8];

wire wr_data = reg_wr & (reg_addr == `ADDR_DATA);
wire rd_data = reg_rd & (reg_addr == `ADDR_DATA);
wire rd_status = reg_rd & (reg_addr == `ADDR_STATUS);
wire tx_accept = wr_data & tx_empty_flag;
wire rx_clear = rd_data & status_seen;
wire rx_pop = rd_data & (rx_byte_count != 3'h0);
wire [3:0] nbits = nine_bit_select ? 4'h9 : 4'h8;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        ctrl1 <= `CTRL1_RESET;
        ctrl2 <= `CTRL2_RESET;
        baud_divisor <= `BAUD_RESET;
        baud_fraction_bits <= `FRAC_RESET;
        status_seen <= 1'b0;
        reg_rdata <= 8'h00;
    end else if (clk_en) begin
        if (reg_wr) begin
            case (reg_addr)
                `ADDR_CTRL1: ctrl1 <= reg_wdata;
                `ADDR_CTRL2: ctrl2 <= reg_wdata;
                `ADDR_BAUD_HI: baud_divisor[15:8] <= reg_wdata;
                `ADDR_BAUD_LO: baud_divisor[7:0] <= reg_wdata;
                `ADDR_FRAC: baud_fraction_bits <= reg_wdata[2:0];
                default: ;
            endcase
        end
        // channel off clears tx and rx enables and break request
        if (!channel_enable_bit) begin
            ctrl2[`CR2_TXEN] <= 1'b0;
            ctrl2[`CR2_RXEN] <= 1'b0;
            ctrl1[`CR1_BREAK] <= 1'b0;
        end
        if (rd_status)
            status_seen <= 1'b1;
        else if (wr_data | rd_data)
            status_seen <= 1'b0;
        reg_rdata <= 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_STATUS: reg_rdata <= {noise_flag, parity_error_flag,
                    framing_error_flag, overrun_flag, rx_idle_flag,
                    tx_idle_flag, tx_empty_flag,
                    rx_byte_count != 3'h0};
                `ADDR_CTRL1: reg_rdata <= ctrl1;
                `ADDR_CTRL2: reg_rdata <= ctrl2;
                `ADDR_DATA: reg_rdata <= fifo_mem[fifo_rp][7:0];
                `ADDR_BAUD_HI: reg_rdata <= baud_divisor[15:8];
                `ADDR_BAUD_LO: reg_rdata <= baud_divisor[7:0];
                `ADDR_FRAC: reg_rdata <= {5'h00, baud_fraction_bits};
                `ADDR_COUNT: reg_rdata <= {rx_ninth_bit, 4'h0,
                    rx_byte_count};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
end

// ==========================================================
// transmitter
localparam TX_IDLE = 3'd0;
localparam TX_START = 3'd1;
localparam TX_DATA = 3'd2;
localparam TX_PAR = 3'd3;
localparam TX_STOP = 3'd4;
localparam TX_BRK = 3'd5;

reg [2:0] tx_state;
reg [8:0] tx_shifter;
reg tx_loaded;
reg [8:0] tx_hold;
reg tx_hold_full;
reg [15:0] tx_cnt;
reg [3:0] tx_bitn;
reg [2:0] tx_acc;
reg tx_par;
reg [15:0] brk_timer;
reg brk_armed;
reg tx_level;

wire [3:0] tx_sum = {1'b0, tx_acc} + {1'b0, baud_fraction_bits};
wire [15:0] tx_reload = baud_divisor + {15'h0000, tx_sum[3]} - 16'h0001;
wire tx_bit_end = (tx_cnt == 16'h0000);
wire [8:0] tx_word = {nine_bit_select & tx_ninth_bit, reg_wdata};
wire tx_abort = !tx_enable_bit & (tx_state != TX_IDLE);
wire tx_last_stop = tx_bitn[0] | !stop_bits_select;

always @* begin
    case (tx_state)
        TX_START: tx_level = 1'b0;
        TX_BRK: tx_level = 1'b0;
        TX_DATA: tx_level = tx_shifter[0];
        TX_PAR: begin
            case (parity_type_select)
                `PAR_EVEN: tx_level = tx_par;
                `PAR_ODD: tx_level = ~tx_par;
                `PAR_MARK: tx_level = 1'b1;
                default: tx_level = 1'b0;
            endcase
        end
        default: tx_level = 1'b1;
    endcase
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        tx_state <= TX_IDLE;
        tx_shifter <= 9'h000;
        tx_loaded <= 1'b0;
        tx_hold <= 9'h000;
        tx_hold_full <= 1'b0;
        tx_cnt <= 16'h0000;
        tx_bitn <= 4'h0;
        tx_acc <= 3'h0;
        tx_par <= 1'b0;
        brk_timer <= 16'h0000;
        brk_armed <= 1'b0;
        tx_empty_flag <= 1'b1;
        tx_idle_flag <= 1'b1;
        tx_out <= 1'b1;
        tx_oe <= 1'b0;
    end else if (clk_en) begin
        tx_out <= tx_level;
        tx_oe <= tx_enable_bit;
        if (send_break_request & tx_idle_flag) begin
            if (brk_timer != 16'hffff)
                brk_timer <= brk_timer + 16'h0001;
        end else begin
            brk_timer <= 16'h0000;
        end
        if (brk_timer > baud_divisor + `BREAK_HOLD_EXTRA)
            brk_armed <= 1'b1;
        else if (!send_break_request & (tx_state != TX_BRK))
            brk_armed <= 1'b0;
        if (tx_accept & status_seen)
            tx_idle_flag <= 1'b0;
        if (tx_accept) begin
            if (!tx_loaded & (tx_state == TX_IDLE)) begin
                tx_shifter <= tx_word;
                tx_loaded <= 1'b1;
            end else begin
                tx_hold <= tx_word;
                tx_hold_full <= 1'b1;
                tx_empty_flag <= 1'b0;
            end
        end
        if (!channel_enable_bit | tx_abort) begin
            tx_state <= TX_IDLE;
            tx_loaded <= 1'b0;
            tx_hold_full <= 1'b0;
            tx_empty_flag <= 1'b1;
            tx_acc <= 3'h0;
            if (!channel_enable_bit)
                tx_idle_flag <= 1'b1;
        end else begin
            if (tx_state != TX_IDLE)
                tx_cnt <= tx_bit_end ? tx_reload : tx_cnt - 16'h0001;
            if (tx_state != TX_IDLE && tx_bit_end)
                tx_acc <= tx_sum[2:0];
            case (tx_state)
                TX_IDLE: begin
                    // start bit adds the fraction to zero, never carries
                    tx_acc <= baud_fraction_bits;
                    tx_bitn <= 4'h0;
                    tx_par <= 1'b0;
                    tx_cnt <= baud_divisor - 16'h0001;
                    if (tx_enable_bit & brk_armed) begin
                        tx_state <= TX_BRK;
                    end else if (tx_enable_bit & tx_loaded) begin
                        tx_state <= TX_START;
                        tx_loaded <= 1'b0;
                    end
                end
                TX_START: if (tx_bit_end) tx_state <= TX_DATA;
                TX_DATA: if (tx_bit_end) begin
                    tx_par <= tx_par ^ tx_shifter[0];
                    tx_shifter <= {1'b0, tx_shifter[8:1]};
                    tx_bitn <= tx_bitn + 4'h1;
                    if (tx_bitn == nbits - 4'h1) begin
                        tx_bitn <= 4'h0;
                        tx_state <= parity_enable_bit ? TX_PAR : TX_STOP;
                    end
                end
                TX_PAR: if (tx_bit_end) tx_state <= TX_STOP;
                TX_BRK: if (tx_bit_end) begin
                    // start bit plus thirteen zeros, repeat while held
                    tx_bitn <= tx_bitn + 4'h1;
                    if (tx_bitn == `BREAK_ZERO_BITS) begin
                        tx_bitn <= 4'h1;
                        if (!send_break_request) begin
                            tx_bitn <= 4'h0;
                            tx_state <= TX_STOP;
                        end
                    end
                end
                TX_STOP: if (tx_bit_end) begin
                    tx_bitn <= tx_bitn + 4'h1;
                    if (tx_last_stop) begin
                        tx_state <= TX_IDLE;
                        tx_idle_flag <= 1'b1;
                        if (tx_hold_full) begin
                            tx_shifter <= tx_hold;
                            tx_loaded <= 1'b1;
                            tx_hold_full <= 1'b0;
                            tx_empty_flag <= 1'b1;
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end
end

// ==========================================================
// receiver and receive fifo
localparam RX_IDLE = 2'd0;
localparam RX_BITS = 2'd1;
localparam RX_WAIT_HIGH = 2'd2;

reg rx_meta;
reg rx_sync;
reg [1:0] rx_state;
reg [11:0] rx_sub;
reg [3:0] rx_phase;
reg [3:0] rx_idx;
reg [2:0] rx_samp;
reg [8:0] rx_shifter;
reg rx_par;
reg rx_noise;
reg rx_perr;

wire [11:0] sub_reload = (baud_divisor[15:4] == 12'h000) ? 12'h000 :
    baud_divisor[15:4] - 12'h001;
wire rx_tick = (rx_sub == 12'h000);
wire rx_vote = (rx_samp[0] & rx_samp[1]) | (rx_samp[0] & rx_samp[2]) |
    (rx_samp[1] & rx_samp[2]);
wire rx_mixed = (rx_samp != 3'h0) & (rx_samp != 3'h7);
wire [3:0] stop_idx = nbits + {3'h0, parity_enable_bit} + 4'h1;
wire rx_bit_done = rx_tick & (rx_phase == `PHASE_LAST);
wire rx_stop_done = (rx_state == RX_BITS) & rx_bit_done & (rx_idx == stop_idx);
wire rx_room = (rx_byte_count != `FIFO_DEPTH);
wire rx_push = rx_stop_done & rx_room;
wire [8:0] rx_word = nine_bit_select ? rx_shifter :
    {1'b0, rx_shifter[8:1]};
wire par_bad = (parity_type_select == `PAR_EVEN) ? rx_par ^ rx_vote :
    (parity_type_select == `PAR_ODD) ? ~(rx_par ^ rx_vote) :
    (parity_type_select == `PAR_MARK) ? ~rx_vote : rx_vote;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        rx_meta <= 1'b1;
        rx_sync <= 1'b1;
        rx_state <= RX_IDLE;
        rx_sub <= 12'h000;
        rx_phase <= 4'h0;
        rx_idx <= 4'h0;
        rx_samp <= 3'h7;
        rx_shifter <= 9'h000;
        rx_par <= 1'b0;
        rx_noise <= 1'b0;
        rx_perr <= 1'b0;
        rx_idle_flag <= 1'b1;
        overrun_flag <= 1'b0;
        framing_error_flag <= 1'b0;
        parity_error_flag <= 1'b0;
        noise_flag <= 1'b0;
        rx_byte_count <= 3'h0;
        fifo_wp <= 2'h0;
        fifo_rp <= 2'h0;
        fifo_mem[0] <= 9'h000;
        fifo_mem[1] <= 9'h000;
        fifo_mem[2] <= 9'h000;
        fifo_mem[3] <= 9'h000;
        irq <= 1'b0;
    end else if (clk_en) begin
        rx_meta <= rx_pin;
        rx_sync <= rx_meta;
        irq <= (tx_empty_flag & tx_empty_irq_enable & !brk_armed) |
            (rx_irq_enable & ((rx_byte_count >= trig_level) |
            overrun_flag));
        if (rx_clear) begin
            overrun_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            noise_flag <= 1'b0;
        end
        rx_sub <= rx_tick ? sub_reload : rx_sub - 12'h001;
        if (rx_tick) begin
            rx_phase <= rx_phase + 4'h1;
            if (rx_phase >= `VOTE_FIRST && rx_phase <= `VOTE_LAST)
                rx_samp <= {rx_samp[1:0], rx_sync};
        end
        case (rx_state)
            RX_IDLE: begin
                if (rx_enable_bit & !rx_sync) begin
                    rx_state <= RX_BITS;
                    rx_idle_flag <= 1'b0;
                    rx_sub <= sub_reload;
                    rx_phase <= 4'h0;
                    rx_idx <= 4'h0;
                    rx_par <= 1'b0;
                    rx_noise <= 1'b0;
                    rx_perr <= 1'b0;
                end
            end
            RX_BITS: if (rx_bit_done) begin
                rx_idx <= rx_idx + 4'h1;
                if (rx_mixed)
                    rx_noise <= 1'b1;
                if (rx_idx == 4'h0 && rx_vote) begin
                    rx_state <= RX_IDLE; // false start
                    rx_idle_flag <= 1'b1;
                end else if (rx_idx != 4'h0 && rx_idx <= nbits) begin
                    rx_shifter <= {rx_vote, rx_shifter[8:1]};
                    rx_par <= rx_par ^ rx_vote;
                end else if (rx_idx != stop_idx) begin
                    rx_perr <= par_bad;
                end else begin
                    // one stop bit only
                    rx_idle_flag <= 1'b1;
                    rx_state <= rx_vote ? RX_IDLE : RX_WAIT_HIGH;
                    if (!rx_room)
                        overrun_flag <= 1'b1;
                    else begin
                        framing_error_flag <= !rx_vote |
                            (framing_error_flag & !rx_clear);
                        parity_error_flag <= rx_perr;
                        noise_flag <= rx_noise | rx_mixed;
                    end
                end
            end
            RX_WAIT_HIGH: if (rx_sync) rx_state <= RX_IDLE;
            default: rx_state <= RX_IDLE;
        endcase
        if (!rx_enable_bit & (rx_state != RX_IDLE)) begin
            rx_state <= RX_IDLE;
            rx_idle_flag <= 1'b1;
        end
        if (rx_push) begin
            fifo_mem[fifo_wp] <= rx_word;
            fifo_wp <= fifo_wp + 2'h1;
        end
        if (rx_pop)
            fifo_rp <= fifo_rp + 2'h1;
        if (rx_push & !rx_pop)
            rx_byte_count <= rx_byte_count + 3'h1;
        else if (rx_pop & !rx_push)
            rx_byte_count <= rx_byte_count - 3'h1;
        if (!channel_enable_bit) begin
            rx_byte_count <= 3'h0;
            fifo_wp <= 2'h0;
            fifo_rp <= 2'h0;
            overrun_flag <= 1'b0;
            framing_error_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            noise_flag <= 1'b0;
            rx_idle_flag <= 1'b1;
        end
    end
end

endmodule

// ### uart_tx_rx_core_assertions.sv
// port assertions for the uart core
`timescale 1ns/1ps
`include "uart_defs.vh"
module uart_core_checker (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    // register port
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // line and irq
    input wire tx_out,
    input wire tx_oe,
    input wire irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // ============================================
    // helpers: tx level run length, irq enables
    reg [7:0] run_len;
    reg last_tx;
    reg ie_on;
    wire wr_ok = reg_wr && clk_en;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_len <= 8'h00;
            last_tx <= 1'b1;
            ie_on <= 1'b0;
        end else begin
            last_tx <= tx_out;
            if (tx_out != last_tx)
                run_len <= 8'h00;
            else if (run_len != 8'hff)
                run_len <= run_len + 8'h01;
            if (wr_ok && reg_addr == `ADDR_CTRL2)
                ie_on <= |reg_wdata[3:2];
        end
    end
    // ============================================
    // assertions
    rdata_idle_a: assert property (
        $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside answer");
    count_bound_a: assert property (
        reg_rd && clk_en && reg_addr == `ADDR_COUNT
        |=> reg_rdata[2:0] <= `FIFO_DEPTH)
        else $error("receive count above depth");
    tx_off_a: assert property (
        wr_ok && reg_addr == `ADDR_CTRL2 && !reg_wdata[`CR2_TXEN]
        |=> ##1 !tx_oe ##1 tx_out)
        else $error("tx pin not released after disable");
    // divisor is back at its reset value of 16 before the bench enables tx
    bit_time_a: assert property (
        tx_out != last_tx && tx_oe |-> run_len >= 8'h0f)
        else $error("tx bit shorter than divisor");
    start_oe_a: assert property (
        $fell(tx_out) |-> tx_oe)
        else $error("frame started with tx disabled");
    oe_write_a: assert property (
        $rose(tx_oe) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("tx pin taken without control write");
    irq_masked_a: assert property (
        !ie_on && !$past(ie_on) |-> !irq)
        else $error("irq raised while masked");
    baud_readback_a: assert property (
        wr_ok && reg_addr == `ADDR_BAUD_LO
        ##1 reg_rd && reg_addr == `ADDR_BAUD_LO
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("divisor low byte not read back");
    cover property ($fell(tx_out));
    cover property (reg_rd && reg_addr == `ADDR_COUNT
        ##1 reg_rdata[2:0] == `FIFO_DEPTH);
    cover property ($rose(irq));
endmodule

bind uart_tx_rx_core uart_core_checker chk_i (.sys_clk, .rst_n, .clk_en,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_out, .tx_oe,
    .irq);

// ### rem_serial_dev.sv
// remote serial device: drives the rx pin, decodes the tx pin
`timescale 1ns/1ps
module rem_serial_dev #(
    parameter int BIT_CYC = 16
) (
    // clock
    input wire sys_clk,
    // serial lines
    input wire line_in,
    output logic line_out,
    // word format
    input wire nine
);
    logic [8:0] got_q[$];
    initial line_out = 1'b1;
    // ============================================
    // sender
    task automatic send_word(input logic [8:0] w, input int gap);
        int i;
        repeat (gap + 1) @(posedge sys_clk);
        line_out <= 1'b0;
        repeat (BIT_CYC) @(posedge sys_clk);
        for (i = 0; i < (nine ? 9 : 8); i++) begin
            line_out <= w[i];
            repeat (BIT_CYC) @(posedge sys_clk);
        end
        line_out <= 1'b1; // one stop bit
        repeat (BIT_CYC) @(posedge sys_clk);
    endtask
    task automatic send_break(input int nbits);
        @(posedge sys_clk);
        line_out <= 1'b0;
        repeat (nbits * BIT_CYC) @(posedge sys_clk);
        line_out <= 1'b1;
        repeat (BIT_CYC) @(posedge sys_clk);
    endtask
    // ============================================
    // receiver, samples mid bit
    initial begin
        logic [8:0] w;
        int i;
        forever begin
            @(negedge line_in);
            repeat (BIT_CYC / 2) @(posedge sys_clk);
            w = 9'h000;
            for (i = 0; i < (nine ? 9 : 8); i++) begin
                repeat (BIT_CYC) @(posedge sys_clk);
                w[i] = line_in;
            end
            repeat (BIT_CYC) @(posedge sys_clk);
            got_q.push_back(w);
        end
    end
endmodule

// ### tb_uart_tx_rx_core.sv
// self-checking bench of the uart core with a queue model
`timescale 1ns/1ps
`include "uart_defs.vh"
module tb_uart_tx_rx_core;
    logic sys_clk, rst_n, clk_en, reg_wr, reg_rd, rx_pin;
    logic tx_out, tx_oe, irq, nine;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rnd;
    logic [8:0] d;
    logic [8:0] exp_q[$];
    int fails, n_compared, i;
    uart_tx_rx_core dut (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .rx_pin, .tx_out, .tx_oe, .irq);
    rem_serial_dev #(.BIT_CYC(16)) far (.sys_clk, .line_in(tx_out),
        .line_out(rx_pin), .nine);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // ============================================
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic print_verdict;
        if (fails == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    task automatic bus(input logic w, input logic r, input logic [2:0] a,
        input logic [7:0] v);
        @(posedge sys_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= v;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        bus(1'b1, 1'b0, a, v);
        bus(1'b0, 1'b0, a, v);
    endtask
    task automatic rd(input logic [2:0] a);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        #1 d = {1'b0, reg_rdata};
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wait_tx(input int n);
        int k;
        for (k = 0; k < 4000 && far.got_q.size() < n; k++)
            @(posedge sys_clk);
        if (far.got_q.size() < n) begin
            fails++;
            print_verdict;
        end
    endtask
    // ============================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        nine = 1'b0;
        rnd = 8'h5c;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`ADDR_STATUS);
        chk("status", 9'h00e, d);
        bus(1'b1, 1'b0, `ADDR_BAUD_LO, 8'h12);
        rd(`ADDR_BAUD_LO);
        chk("divisor", 9'h012, d);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(`ADDR_BAUD_LO, 8'h10);
        clk_en <= 1'b1;
        rd(`ADDR_BAUD_LO);
        chk("frozen", 9'h012, d);
        wr(`ADDR_BAUD_LO, 8'h10);
        wr(`ADDR_CTRL1, 8'h01);
        wr(`ADDR_CTRL2, 8'h03);
        cyc(3);
        chk("idle line", 9'h003, {7'h00, tx_oe, tx_out});
        for (i = 0; i < 3; i++) begin
            rnd = lfsr(rnd);
            rd(`ADDR_STATUS);
            wr(`ADDR_DATA, rnd);
            if (i < 2)
                exp_q.push_back({1'b0, rnd});
            rd(`ADDR_STATUS);
            chk("tx empty", {8'h00, i == 0}, {8'h00, d[1]});
        end
        wait_tx(2);
        while (exp_q.size() > 0)
            chk("tx word", exp_q.pop_front(), far.got_q.pop_front());
        cyc(12);
        rd(`ADDR_STATUS);
        chk("tx idle", 9'h003, {7'h00, d[2:1]});
        rd(`ADDR_STATUS);
        wr(`ADDR_DATA, 8'h96);
        rd(`ADDR_STATUS);
        chk("idle cleared", 9'h000, {8'h00, d[2]});
        wait_tx(1);
        chk("tx word", 9'h096, far.got_q.pop_front());
        cyc(12);
        wr(`ADDR_CTRL1, 8'h83);
        nine = 1'b1;
        rd(`ADDR_STATUS);
        wr(`ADDR_DATA, 8'h5a);
        wait_tx(1);
        chk("tx nine", 9'h15a, far.got_q.pop_front());
        far.send_word(9'h1a5, 3);
        cyc(20);
        rd(`ADDR_COUNT);
        chk("count nine", 9'h081, d);
        rd(`ADDR_DATA);
        chk("rx nine", 9'h0a5, d);
        // odd parity; far side reads the parity bit as a ninth bit
        wr(`ADDR_CTRL1, 8'h0d);
        rnd = lfsr(rnd);
        rd(`ADDR_STATUS);
        wr(`ADDR_DATA, rnd);
        wait_tx(1);
        chk("tx parity", {~^rnd, rnd}, far.got_q.pop_front());
        far.send_word({^rnd, rnd}, 3);
        cyc(20);
        rd(`ADDR_STATUS);
        chk("parity error", 9'h001, {8'h00, d[6]});
        rd(`ADDR_DATA);
        chk("rx parity data", {1'b0, rnd}, d);
        wr(`ADDR_CTRL1, 8'h01);
        nine = 1'b0;
        wr(`ADDR_CTRL2, 8'h3b);
        for (i = 0; i < 5; i++) begin
            if (i >= 3) begin
                cyc(20);
                chk("irq level", {8'h00, i == 4}, {8'h00, irq});
            end
            rnd = lfsr(rnd);
            if (i < 4)
                exp_q.push_back({1'b0, rnd});
            far.send_word({1'b0, rnd}, i);
        end
        cyc(20);
        rd(`ADDR_COUNT);
        chk("rx count", 9'h004, d);
        rd(`ADDR_STATUS);
        chk("overrun", 9'h003, {7'h00, d[4], d[0]});
        while (exp_q.size() > 0) begin
            rd(`ADDR_DATA);
            chk("rx word", exp_q.pop_front(), d);
        end
        rd(`ADDR_STATUS);
        rd(`ADDR_DATA);
        rd(`ADDR_STATUS);
        chk("flags cleared", 9'h000, {7'h00, d[4], d[0]});
        wr(`ADDR_CTRL2, 8'h03);
        far.send_break(14);
        cyc(40);
        rd(`ADDR_COUNT);
        chk("break count", 9'h001, d);
        rd(`ADDR_STATUS);
        chk("break flags", 9'h003, {7'h00, d[5], d[3]});
        rd(`ADDR_DATA);
        chk("break data", 9'h000, d);
        far.send_word(9'h0c3, 2);
        cyc(20);
        rd(`ADDR_DATA);
        chk("after break", 9'h0c3, d);
        wr(`ADDR_CTRL1, 8'h41);
        cyc(60);
        wr(`ADDR_CTRL1, 8'h01);
        wait_tx(1);
        chk("tx break", 9'h000, far.got_q.pop_front());
        cyc(100);
        rd(`ADDR_STATUS);
        wr(`ADDR_DATA, 8'h00);
        cyc(40);
        wr(`ADDR_CTRL2, 8'h02);
        cyc(4);
        rd(`ADDR_STATUS);
        chk("abort", 9'h003, {6'h00, tx_oe, tx_out, d[1]});
        cyc(200);
        far.got_q.delete();
        rd(`ADDR_STATUS);
        wr(`ADDR_DATA, 8'hc5);
        cyc(40);
        chk("held", 9'h000, {8'h00, tx_oe});
        wr(`ADDR_CTRL2, 8'h03);
        wait_tx(1);
        chk("late start", 9'h0c5, far.got_q.pop_front());
        print_verdict;
    end
endmodule
